// ### break_unit_pkg.sv
// Constants shared by the address break unit and its vector helper
package break_unit_pkg;
  localparam int          ADDR_W                 = 16;
  localparam logic [7:0]  SOFTWARE_INTERRUPT_OP  = 8'h83;
  localparam logic [7:0]  RETURN_FROM_INTERRUPT  = 8'h80;
  localparam logic [7:0]  OPCODE_RESET           = 8'h00;
  localparam logic [15:0] VECTOR_NORMAL_HI       = 16'hfffc;
  localparam logic [15:0] VECTOR_NORMAL_LO       = 16'hfffd;
  localparam logic [15:0] VECTOR_MONITOR_HI      = 16'hfefc;
  localparam logic [15:0] VECTOR_MONITOR_LO      = 16'hfefd;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_INJECT = 2'b01,
    ST_ACTIVE = 2'b11
  } break_state_t;
endpackage

// ### vector_if.sv
// Interface carrying vector selection between break unit and helper
`timescale 1ns/100ps
interface vector_if;
  logic        monitor_mode;
  logic [15:0] vector_hi;
  logic [15:0] vector_lo;
  modport chooser (input monitor_mode, output vector_hi, output vector_lo);
  modport user    (output monitor_mode, input vector_hi, input vector_lo);
endinterface

// ### break_vector_select.sv
// Selects the break vector address pair by monitor mode
`timescale 1ns/100ps
module break_vector_select
  import break_unit_pkg::*;
(
  vector_if.chooser vif      // Mode in, vector pair out
);
  // Pick normal or monitor pair
  always_comb
  begin
    if (vif.monitor_mode)
    begin
      vif.vector_hi = VECTOR_MONITOR_HI;
      vif.vector_lo = VECTOR_MONITOR_LO;
    end
    else
    begin
      vif.vector_hi = VECTOR_NORMAL_HI;
      vif.vector_lo = VECTOR_NORMAL_LO;
    end
  end
endmodule

// ### address_break_module.sv
// Address break unit: match detection, opcode forcing and break tracking
`timescale 1ns/100ps
// Functional notes
// - Assert low request on break address match
// - Only program counter fetch addresses may match
// - Force software interrupt opcode into CPU
// - Vector pair depends on monitor mode
// - Writing break active bit raises break
// - Return from interrupt ends the break
// - Hold watchdog off during break
// - Keep I/O registers accessible during break
module address_break_module
  import break_unit_pkg::*;
#(
  parameter int AW = ADDR_W                   // Address width
)
(
  input  wire logic          i_clock,          // 40 MHz bus clock
  input  wire logic          i_resetn,         // Async reset, active low
  input  wire logic [AW-1:0] i_address,        // Internal address bus
  input  wire logic          i_pc_fetch,       // Address comes from program counter
  input  wire logic [7:0]    i_fetch_opcode,   // Opcode fetched from memory
  input  wire logic          i_opcode_load,    // CPU loads instruction register
  input  wire logic [AW-1:0] i_break_address,  // Break address value
  input  wire logic          i_break_enable,   // Enables address match breaks
  input  wire logic          i_break_active_set,  // Software writes 1 to break active bit
  input  wire logic          i_monitor_mode,   // Monitor mode active
  input  wire logic          i_io_access,      // I/O register access request
  output logic               o_breakpoint_request_n, // Break request, active low
  output logic [7:0]         o_opcode,         // Opcode for instruction register
  output logic [15:0]        o_vector_hi,      // Vector high byte address
  output logic [15:0]        o_vector_lo,      // Vector low byte address
  output logic               o_break_active_bit,  // Break in progress
  output logic               o_watchdog_hold,  // Freeze watchdog
  output logic               o_io_grant        // I/O access allowed
);
  break_state_t  state_reg;      // Break sequencing state
  break_state_t  state_next;     // Next sequencing state
  logic [AW-1:0] bit_equal;      // Per bit address equality
  logic          match;          // Program counter address hit
  logic          trigger;        // Any break cause this cycle
  logic          rti_seen;       // Return opcode being loaded
  logic [7:0]    opcode_next;    // Next instruction register feed
  vector_if      vif ();         // Vector selection carrier

  // True while the request line must stay low
  function automatic logic is_pending(input break_state_t s);
    is_pending = (s == ST_INJECT);
  endfunction

  // True from trigger until the return opcode
  function automatic logic is_busy(input break_state_t s);
    is_busy = (s != ST_IDLE);
  endfunction

  // All bits equal, no partial compare
  function automatic logic addr_hit(input logic [AW-1:0] eq);
    addr_hit = &eq;
  endfunction

  // Bitwise compare across the full address width
  genvar gi;
  generate
    for (gi = 0; gi < AW; gi++)
    begin : g_bit_cmp
      assign bit_equal[gi] = (i_address[gi] == i_break_address[gi]);
    end
  endgenerate

  // Only program counter fetches are break candidates
  assign match    = i_break_enable && i_pc_fetch && addr_hit(bit_equal);
  // Software request needs no hit; ignored while busy
  assign trigger  = match || i_break_active_set;
  // Return opcode as the instruction register loads it
  assign rti_seen = i_opcode_load && (i_fetch_opcode == RETURN_FROM_INTERRUPT);
  assign vif.monitor_mode = i_monitor_mode;

  break_vector_select u_vec
  (
    .vif (vif)   // Mode in, vector pair out
  );

  // Next state of break sequencing
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (trigger)
          state_next = ST_INJECT;
      end
      ST_INJECT:
      begin
        if (i_opcode_load)
          state_next = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (rti_seen)
          state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Interrupt opcode replaces the fetch while pending
  always_comb
  begin
    if (is_pending(state_next))
      opcode_next = SOFTWARE_INTERRUPT_OP;
    else
      opcode_next = i_fetch_opcode;
  end

  // State register
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Request line, low while break pending
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_breakpoint_request_n <= 1'b1;
    end
    else
    begin
      o_breakpoint_request_n <= !is_pending(state_next);
    end
  end

  // Instruction register feed
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_opcode <= OPCODE_RESET;
    end
    else
    begin
      o_opcode <= opcode_next;
    end
  end

  // Vector high byte address
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_vector_hi <= VECTOR_NORMAL_HI;
    end
    else
    begin
      o_vector_hi <= vif.vector_hi;
    end
  end

  // Vector low byte address
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_vector_lo <= VECTOR_NORMAL_LO;
    end
    else
    begin
      o_vector_lo <= vif.vector_lo;
    end
  end

  // Break active status, set by trigger, cleared by return
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_break_active_bit <= 1'b0;
    end
    else
    begin
      o_break_active_bit <= is_busy(state_next);
    end
  end

  // Watchdog frozen for the whole break
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_watchdog_hold <= 1'b0;
    end
    else
    begin
      o_watchdog_hold <= is_busy(state_next);
    end
  end

  // I/O access passes through, never blocked by a break
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_io_grant <= 1'b0;
    end
    else
    begin
      o_io_grant <= i_io_access;
    end
  end
endmodule

// ### break_unit_properties.sv
// Checker for the address break unit ports
`timescale 1ns/100ps
module break_unit_properties
  import break_unit_pkg::*;
#(parameter int AW = ADDR_W)
(
  input wire logic i_clock, i_resetn, i_pc_fetch, i_opcode_load, i_break_enable, i_break_active_set,
  input wire logic i_monitor_mode, i_io_access, o_breakpoint_request_n, o_break_active_bit,
  input wire logic o_watchdog_hold, o_io_grant,
  input wire logic [AW-1:0] i_address, i_break_address,
  input wire logic [7:0] i_fetch_opcode, o_opcode,
  input wire logic [15:0] o_vector_hi
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Trigger and return terms
  wire idle = !o_break_active_bit;
  wire hit = i_break_enable && i_pc_fetch && i_address == i_break_address;
  wire return_from_interrupt_op = i_opcode_load && i_fetch_opcode == RETURN_FROM_INTERRUPT;
  a_match_req: assert property (idle && hit |=> !o_breakpoint_request_n)
    else $error("no request");
  a_nonpc_quiet: assert property (idle && !hit && !i_break_active_set |=> o_breakpoint_request_n)
    else $error("stray request");
  a_swi_forced: assert property (!o_breakpoint_request_n |-> o_opcode == SOFTWARE_INTERRUPT_OP)
    else $error("bad opcode");
  a_vector_mode: assert property
    (o_vector_hi == ($past(i_monitor_mode) ? VECTOR_MONITOR_HI : VECTOR_NORMAL_HI)) else $error("bad vector");
  a_set_active: assert property (idle && i_break_active_set |=> o_break_active_bit)
    else $error("no soft break");
  a_rti_ends: assert property (o_break_active_bit && o_breakpoint_request_n && return_from_interrupt_op |=> idle)
    else $error("break kept");
  a_wdog_hold: assert property (o_watchdog_hold == o_break_active_bit)
    else $error("bad hold");
  a_io_grant: assert property (o_io_grant == $past(i_io_access))
    else $error("io blocked");
  c_match: cover property (idle && hit);
  c_soft: cover property (idle && i_break_active_set);
  c_end: cover property (o_break_active_bit && return_from_interrupt_op);
endmodule
bind address_break_module break_unit_properties #(.AW(AW)) props (.*);

// ### cpu_side_model.sv
// Model of the CPU and system integration side
`timescale 1ns/100ps
module cpu_side_model
(
  input  wire logic       i_clock,  // Bus clock
  input  wire logic       i_req_n,  // Break request, active low
  input  wire logic       i_stall,  // Delay the opcode load
  input  wire logic       i_rti,    // Fetch a return opcode
  output logic            o_load,   // Instruction register load
  output logic [7:0]      o_op      // Fetched opcode
);
  logic [8:0] n;
  initial {o_load, o_op} = 9'h0;
  // Sample at the edge, answer just after it
  always @(posedge i_clock)
  begin
    n = {(!i_req_n && !i_stall) || i_rti, i_rti ? 8'h80 : 8'h9d};
    #1 {o_load, o_op} = n;
  end
endmodule

// ### address_break_module_tb.sv
// Self-checking bench for the address break unit
`timescale 1ns/100ps
module address_break_module_tb;
  logic clk = 0, rstn = 0, pc = 0, en = 0, set = 0, mon = 0, io = 0, return_from_interrupt_op = 0, stall = 1;
  logic load, trig, req_n, act, grant, hold;
  logic [7:0] fop, op;
  logic [15:0] a = 0, ba = 0, vh, vl;
  int fails = 0, total_checks = 0, seed = 32'he178, cyc = 0;
  address_break_module uut (.i_clock(clk), .i_resetn(rstn), .i_address(a), .i_pc_fetch(pc),
    .i_fetch_opcode(fop), .i_opcode_load(load), .i_break_address(ba), .i_break_enable(en),
    .i_break_active_set(set), .i_monitor_mode(mon), .i_io_access(io), .o_breakpoint_request_n(req_n),
    .o_opcode(op), .o_vector_hi(vh), .o_vector_lo(vl), .o_break_active_bit(act), .o_watchdog_hold(hold),
    .o_io_grant(grant));
  cpu_side_model cpu (.i_clock(clk), .i_req_n(req_n), .i_stall(stall), .i_rti(return_from_interrupt_op), .o_load(load), .o_op(fop));
  initial forever #12.5 clk = ~clk;
  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Expected vector address by mode and byte
  function automatic logic [15:0] exp_vec(input logic m, input logic lo);
    exp_vec = m ? (lo ? 16'hfefd : 16'hfefc) : (lo ? 16'hfffd : 16'hfffc);
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fails++;
      print_verdict;
    end
  end
  // Random fetches with forced hits and soft breaks
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rstn = 1;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clk);
      #1 ba = 16'($random(seed));
      a = (i % 3 == 0) ? ba : 16'($random(seed));
      {pc, en, mon, io} = 4'($random(seed));
      set = (i % 7 == 3);
      trig = (en && pc && a == ba) || set;
      @(posedge clk);
      #1 {pc, set} = 2'b00;
      chk(req_n, !trig);
      chk(act, trig);
      chk(grant, io);
      chk(vh, exp_vec(mon, 1'b0));
      chk(vl, exp_vec(mon, 1'b1));
      chk(hold, trig);
      if (trig)
      begin
        chk(op, 8'h83);
        stall = 0;
        @(posedge clk);
        #1 stall = 1;
        @(posedge clk);
        #1 chk(req_n, 1);
        return_from_interrupt_op = 1;
        set = 1;
        @(posedge clk);
        #1 return_from_interrupt_op = 0;
        set = 0;
        @(posedge clk);
        #1 chk(act, 0);
        chk(hold, 0);
        chk(req_n, 1);
      end
    end
    $display("break sequence test done");
    print_verdict;
  end
endmodule
